// [design/trsc_top.sv]
// trsc_top: track enable/arming, input-to-track routing mode, send source and slate.
// assumes operator pins are asynchronous; encoder steps, input activity,
// media routing, talkback requests and menu strobes come from sys_clk logic.
`timescale 1ns/10ps
// Overview of operation
// - short track press toggles its enable, except selected track in routing mode.
// - disabled track keeps its indicator off.
// - enabled but unarmed track flashes blue.
// - enabled track with media and an active routed input is armed, steady blue.
// - one-second track hold enters routing mode; selected track flashes green.
// - routing mode solos the selected track in the headphones.
// - enter from any mode; short press of selected track exits to trim.
// - in routing mode, short encoder press toggles that input's routing.
// - ring off if unrouted, green pre-fade, red post-fade.
// - half-second encoder hold toggles pre/post fade for the selected track.
// - send source is off, built-in or input 8; resets to off.
// - with source off, slate and talkback requests are ignored.
// - while slate or talkback active, input 8 destinations carry send signal.
// - external source blocks routing of input 8 to tracks.
// - active slate replaces program on every destination in its mask.
// - slate mask resets with every destination selected.
// - setup select press inverts the highlighted destination's mask bit.
// - shift press then slate switch right activates slate; indicator flashes blue.
// - slate gain spans -40 to +6 dB in 1 dB steps.
// - headphone control turns change gain while held; value shown briefly.
// - slate switch release ends slate; shift stays latched and flashing.
module trsc_top import trsc_pkg::*; #(
    parameter int N_TRACKS = TRSC_N_TRACKS,
    parameter int N_INPUTS = TRSC_N_INPUTS,
    parameter int N_OUTPUTS = TRSC_N_OUTPUTS,
    parameter int N_PHONES = TRSC_N_PHONES,
    parameter int MS_CYCLES = TRSC_TICK_CYCLES,
    parameter int MASK_W = N_TRACKS + N_OUTPUTS + N_PHONES,
    parameter int SEL_W = $clog2(N_TRACKS),
    parameter int IDX_W = $clog2(MASK_W)
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [N_TRACKS-1:0] track_btn,
    input wire logic [N_INPUTS-1:0] enc_btn,
    input wire logic shift_btn,
    input wire logic slate_sw,
    input wire logic [N_INPUTS-1:0] input_on,
    input wire logic [N_TRACKS-1:0] track_media,
    input wire logic talkback_circuit_one_req,
    input wire logic talkback_circuit_two_req,
    input wire logic hp_step,
    input wire logic hp_up,
    input wire logic setup_toggle,
    input wire logic [IDX_W-1:0] setup_index,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [N_TRACKS-1:0] track_led_blue,
    output logic [N_TRACKS-1:0] track_led_green,
    output logic [N_INPUTS-1:0] ring_green,
    output logic [N_INPUTS-1:0] ring_red,
    output logic route_mode_on,
    output logic [SEL_W-1:0] sel_track,
    output logic hp_solo_en,
    output logic force_trim,
    output logic shift_led_blue,
    output logic talkback_two_return_two_indicator,
    output logic slate_on,
    output logic talkback_circuit_one_on,
    output logic talkback_circuit_two_on,
    output logic in8_send,
    output logic in8_route_block,
    output logic [MASK_W-1:0] slate_dest,
    output logic gain_show,
    output logic [6:0] slate_gain
);
    localparam int PINS = N_TRACKS + N_INPUTS + 2;

    function automatic logic [SEL_W-1:0] lowest_set(input logic [N_TRACKS-1:0] v);
        lowest_set = '0;
        for (int i = N_TRACKS - 1; i >= 0; i--) begin
            if (v[i]) begin
                lowest_set = SEL_W'(i);
            end
        end
    endfunction

    logic [PINS-1:0] pin_meta;
    logic [PINS-1:0] pin_sync;
    logic shift_s;
    logic slate_s;
    logic shift_prev;
    logic slate_prev;
    logic ms_tick;
    logic blink;
    trsc_mode_t mode;
    logic [SEL_W-1:0] sel;
    logic [N_TRACKS-1:0] track_en;
    logic [N_INPUTS-1:0] route [N_TRACKS];
    logic [N_TRACKS-1:0] postfade;
    trsc_src_t src;
    logic [MASK_W-1:0] mask;
    logic shift_lat;
    logic [10:0] show_cnt;
    logic [N_TRACKS-1:0] sel_mask;
    logic [N_INPUTS-1:0] blk;
    logic [N_TRACKS-1:0] armed;
    logic src_en;
    logic send_busy;

    trsc_press_if #(.N(N_TRACKS)) trk_if ();
    trsc_press_if #(.N(N_INPUTS)) enc_if ();

    // first stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {slate_sw, shift_btn, enc_btn, track_btn};
            pin_sync <= pin_meta;
        end
    end

    assign trk_if.held = pin_sync[N_TRACKS-1:0];
    assign enc_if.held = pin_sync[N_TRACKS+N_INPUTS-1:N_TRACKS];
    assign shift_s = pin_sync[PINS-2];
    assign slate_s = pin_sync[PINS-1];
    assign trk_if.tick = ms_tick;
    assign enc_if.tick = ms_tick;

    trsc_tick #(.MS_CYCLES(MS_CYCLES)) u_tick (
        .sys_clk(sys_clk),
        .rst(rst),
        .ms_tick(ms_tick),
        .blink(blink)
    );

    trsc_press #(.N(N_TRACKS), .HOLD_MS(TRSC_TRACK_HOLD_MS)) u_trk_press (
        .sys_clk(sys_clk),
        .rst(rst),
        .pif(trk_if)
    );

    trsc_press #(.N(N_INPUTS), .HOLD_MS(TRSC_ENC_HOLD_MS)) u_enc_press (
        .sys_clk(sys_clk),
        .rst(rst),
        .pif(enc_if)
    );

    always_comb begin
        sel_mask = '0;
        if (mode == TRSC_MODE_ROUTE) begin
            sel_mask[sel] = 1'b1;
        end
        blk = '0;
        blk[TRSC_SEND_INPUT] = (src == TRSC_SRC_EXT);
        for (int t = 0; t < N_TRACKS; t++) begin
            armed[t] = track_en[t] & track_media[t] & (|(route[t] & input_on & ~blk));
        end
    end

    assign src_en = (src != TRSC_SRC_OFF);
    assign send_busy = slate_on | (src_en & (talkback_circuit_one_req
                                            | talkback_circuit_two_req));

    // surface mode; a new long press may reselect while already routing
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mode <= TRSC_MODE_TRIM;
            sel <= '0;
            force_trim <= 1'b0;
        end else begin
            force_trim <= 1'b0;
            if (|trk_if.long_p) begin
                mode <= TRSC_MODE_ROUTE;
                sel <= lowest_set(trk_if.long_p);
            end else if (mode == TRSC_MODE_ROUTE && trk_if.short_p[sel]) begin
                mode <= TRSC_MODE_TRIM;
                force_trim <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            track_en <= '0;
        end else begin
            track_en <= track_en ^ (trk_if.short_p & ~sel_mask);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            postfade <= '0;
            for (int t = 0; t < N_TRACKS; t++) begin
                route[t] <= '0;
            end
        end else if (mode == TRSC_MODE_ROUTE) begin
            route[sel] <= route[sel] ^ (enc_if.short_p & ~blk);
            if (|enc_if.long_p) begin
                postfade[sel] <= ~postfade[sel];
            end
        end
    end

    // a disabled track stays dark even when selected for routing
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            track_led_blue <= '0;
            track_led_green <= '0;
        end else begin
            for (int t = 0; t < N_TRACKS; t++) begin
                if (!track_en[t]) begin
                    track_led_blue[t] <= 1'b0;
                    track_led_green[t] <= 1'b0;
                end else if (sel_mask[t]) begin
                    track_led_blue[t] <= 1'b0;
                    track_led_green[t] <= blink;
                end else begin
                    track_led_blue[t] <= armed[t] | blink;
                    track_led_green[t] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ring_green <= '0;
            ring_red <= '0;
            route_mode_on <= 1'b0;
            hp_solo_en <= 1'b0;
            sel_track <= '0;
        end else begin
            route_mode_on <= (mode == TRSC_MODE_ROUTE);
            hp_solo_en <= (mode == TRSC_MODE_ROUTE);
            sel_track <= sel;
            if (mode == TRSC_MODE_ROUTE) begin
                ring_green <= (route[sel] & ~blk) & {N_INPUTS{~postfade[sel]}};
                ring_red <= (route[sel] & ~blk) & {N_INPUTS{postfade[sel]}};
            end else begin
                ring_green <= '0;
                ring_red <= '0;
            end
        end
    end

    // shift latch and slate activation
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            shift_prev <= 1'b0;
            slate_prev <= 1'b0;
            shift_lat <= 1'b0;
            slate_on <= 1'b0;
        end else begin
            shift_prev <= shift_s;
            slate_prev <= slate_s;
            if (shift_s && !shift_prev) begin
                shift_lat <= ~shift_lat;
            end
            if (!src_en || !slate_s) begin
                slate_on <= 1'b0;
            end else if (!slate_prev && shift_lat) begin
                slate_on <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            shift_led_blue <= 1'b0;
            talkback_two_return_two_indicator <= 1'b0;
            talkback_circuit_one_on <= 1'b0;
            talkback_circuit_two_on <= 1'b0;
            in8_send <= 1'b0;
            in8_route_block <= 1'b0;
            slate_dest <= '0;
        end else begin
            shift_led_blue <= shift_lat & blink;
            talkback_two_return_two_indicator <= slate_on & blink;
            talkback_circuit_one_on <= talkback_circuit_one_req & src_en;
            talkback_circuit_two_on <= talkback_circuit_two_req & src_en;
            in8_send <= send_busy;
            in8_route_block <= (src == TRSC_SRC_EXT);
            slate_dest <= slate_on ? mask : '0;
        end
    end

    // gain only moves while the switch is physically held with slate live
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            slate_gain <= TRSC_GAIN_RST;
            show_cnt <= '0;
            gain_show <= 1'b0;
        end else begin
            gain_show <= (show_cnt != '0);
            if (slate_on && slate_s && hp_step) begin
                show_cnt <= 11'(TRSC_GAIN_SHOW_MS);
                if (hp_up && slate_gain != TRSC_GAIN_MAX) begin
                    slate_gain <= slate_gain + 7'h01;
                end else if (!hp_up && slate_gain != TRSC_GAIN_MIN) begin
                    slate_gain <= slate_gain - 7'h01;
                end
            end else if (ms_tick && show_cnt != '0) begin
                show_cnt <= show_cnt - 11'h001;
            end
        end
    end

    // software writes; a menu toggle in the same cycle acts after the write
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            src <= TRSC_SRC_OFF;
            mask <= '1;
        end else begin
            if (reg_wr && reg_addr == TRSC_REG_SRC && reg_wdata[1:0] != 2'h3) begin
                src <= trsc_src_t'(reg_wdata[1:0]);
            end
            if (setup_toggle && 32'(setup_index) < MASK_W) begin
                mask[setup_index] <= ~((reg_wr && reg_addr == TRSC_REG_MASK)
                                       ? reg_wdata[setup_index] : mask[setup_index]);
                for (int i = 0; i < MASK_W; i++) begin
                    if (i != 32'(setup_index) && reg_wr && reg_addr == TRSC_REG_MASK) begin
                        mask[i] <= reg_wdata[i];
                    end
                end
            end else if (reg_wr && reg_addr == TRSC_REG_MASK) begin
                mask <= reg_wdata[MASK_W-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                TRSC_REG_SRC: reg_rdata <= 32'(src);
                TRSC_REG_MASK: reg_rdata <= 32'(mask);
                TRSC_REG_GAIN: reg_rdata <= 32'(slate_gain);
                TRSC_REG_TRK_EN: reg_rdata <= 32'(track_en);
                TRSC_REG_ARMED: reg_rdata <= 32'(armed);
                TRSC_REG_STATUS: begin
                    reg_rdata <= '0;
                    reg_rdata[TRSC_STAT_ROUTE_BIT] <= (mode == TRSC_MODE_ROUTE);
                    reg_rdata[TRSC_STAT_SLATE_BIT] <= slate_on;
                    reg_rdata[TRSC_STAT_SHIFT_BIT] <= shift_lat;
                    reg_rdata[TRSC_STAT_SEL_LSB +: SEL_W] <= sel;
                end
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_disabled_dark;
        1'b1 |=> ((track_led_blue | track_led_green) & ~$past(track_en)) == '0;
    endproperty
    a_disabled_dark: assert property (p_disabled_dark) else $error("disabled track lit");

    property p_armed_steady;
        1'b1 |=> (track_led_blue & $past(armed & ~sel_mask)) == $past(armed & ~sel_mask);
    endproperty
    a_armed_steady: assert property (p_armed_steady) else $error("armed track not blue");

    property p_enter_route;
        (|trk_if.long_p) |=> mode == TRSC_MODE_ROUTE ##1 route_mode_on && hp_solo_en;
    endproperty
    a_enter_route: assert property (p_enter_route) else $error("long press no route");

    property p_toggle_enable;
        trk_if.short_p[0] && !sel_mask[0] |=> track_en[0] != $past(track_en[0]);
    endproperty
    a_toggle_enable: assert property (p_toggle_enable) else $error("track not toggled");

    property p_exit_route;
        mode == TRSC_MODE_ROUTE && trk_if.short_p[sel] && !(|trk_if.long_p)
            |=> mode == TRSC_MODE_TRIM && force_trim && $stable(track_en[sel]);
    endproperty
    a_exit_route: assert property (p_exit_route) else $error("route exit wrong");

    property p_src_off_ignores;
        src == TRSC_SRC_OFF
            |=> !slate_on && !talkback_circuit_one_on && !talkback_circuit_two_on;
    endproperty
    a_src_off_ignores: assert property (p_src_off_ignores) else $error("send while off");

    property p_in8_send;
        slate_on |=> in8_send;
    endproperty
    a_in8_send: assert property (p_in8_send) else $error("input 8 not taken");

    property p_ext_blocks;
        src == TRSC_SRC_EXT && !(|trk_if.long_p) |=> $stable(route[sel][TRSC_SEND_INPUT]);
    endproperty
    a_ext_blocks: assert property (p_ext_blocks) else $error("input 8 routed");

    property p_gain_range;
        $signed(slate_gain) >= $signed(TRSC_GAIN_MIN)
            && $signed(slate_gain) <= $signed(TRSC_GAIN_MAX);
    endproperty
    a_gain_range: assert property (p_gain_range) else $error("gain out of range");

    property p_release_ends;
        slate_on && !slate_s && !(shift_s && !shift_prev)
            |=> !slate_on && shift_lat == $past(shift_lat);
    endproperty
    a_release_ends: assert property (p_release_ends) else $error("slate kept");

    c_route: cover property (mode == TRSC_MODE_ROUTE && (|enc_if.short_p));
    c_postfade: cover property (mode == TRSC_MODE_ROUTE && (|enc_if.long_p));
    c_slate: cover property (slate_on && hp_step);
    c_mask: cover property (setup_toggle);
endmodule

// [shared/trsc_pkg.sv]
// trsc_pkg: constants and types for the track routing and slate control block.
// assumes a single 50 MHz system clock; all counts derive from it here.
package trsc_pkg;

    localparam int TRSC_CLK_HZ = 50_000_000;
    localparam int TRSC_TICK_US = 1000;
    localparam int TRSC_TICK_CYCLES = TRSC_CLK_HZ / 1_000_000 * TRSC_TICK_US;

    // hold thresholds and display timings, in millisecond ticks
    localparam int TRSC_TRACK_HOLD_MS = 1000;
    localparam int TRSC_ENC_HOLD_MS = 500;
    localparam int TRSC_BLINK_MS = 250;
    localparam int TRSC_GAIN_SHOW_MS = 2000;

    localparam int TRSC_N_TRACKS = 12;
    localparam int TRSC_N_INPUTS = 8;
    localparam int TRSC_N_OUTPUTS = 6;
    localparam int TRSC_N_PHONES = 2;
    // zero-based index of input 8, whose path the send source borrows
    localparam int TRSC_SEND_INPUT = 7;

    // slate gain in dB, two's complement
    localparam logic [6:0] TRSC_GAIN_MIN = 7'h58;
    localparam logic [6:0] TRSC_GAIN_MAX = 7'h06;
    localparam logic [6:0] TRSC_GAIN_RST = 7'h00;

    typedef enum logic [1:0] {
        TRSC_SRC_OFF = 2'h0,
        TRSC_SRC_BUILTIN = 2'h1,
        TRSC_SRC_EXT = 2'h2
    } trsc_src_t;

    typedef enum logic {
        TRSC_MODE_TRIM = 1'b0,
        TRSC_MODE_ROUTE = 1'b1
    } trsc_mode_t;

    // register map, byte offsets
    localparam logic [7:0] TRSC_REG_SRC = 8'h00;
    localparam logic [7:0] TRSC_REG_MASK = 8'h04;
    localparam logic [7:0] TRSC_REG_GAIN = 8'h08;
    localparam logic [7:0] TRSC_REG_TRK_EN = 8'h0C;
    localparam logic [7:0] TRSC_REG_ARMED = 8'h10;
    localparam logic [7:0] TRSC_REG_STATUS = 8'h14;

    // status register fields
    localparam int TRSC_STAT_ROUTE_BIT = 0;
    localparam int TRSC_STAT_SLATE_BIT = 1;
    localparam int TRSC_STAT_SHIFT_BIT = 2;
    localparam int TRSC_STAT_SEL_LSB = 8;

endpackage

// [shared/trsc_press_if.sv]
// trsc_press_if: held levels in, short and long press pulses out.
// assumes held levels are already synchronised to sys_clk.
`timescale 1ns/10ps
interface trsc_press_if #(parameter int N = 1);
    logic tick;
    logic [N-1:0] held;
    logic [N-1:0] short_p;
    logic [N-1:0] long_p;
    modport cls (input tick, input held, output short_p, output long_p);
    modport user (output tick, output held, input short_p, input long_p);
endinterface

// [design/trsc_tick.sv]
// trsc_tick: millisecond tick and indicator blink phase.
// assumes sys_clk at the rate set in the package; MS_CYCLES may be shortened in sim.
`timescale 1ns/10ps
module trsc_tick import trsc_pkg::*; #(
    parameter int MS_CYCLES = TRSC_TICK_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    output logic ms_tick,
    output logic blink
);
    logic [$clog2(MS_CYCLES+1)-1:0] div;
    logic [$clog2(TRSC_BLINK_MS+1)-1:0] bcnt;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            div <= '0;
            ms_tick <= 1'b0;
        end else begin
            ms_tick <= (div == ($bits(div))'(MS_CYCLES - 1));
            div <= (div == ($bits(div))'(MS_CYCLES - 1)) ? '0 : div + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bcnt <= '0;
            blink <= 1'b0;
        end else if (ms_tick) begin
            if (bcnt == ($bits(bcnt))'(TRSC_BLINK_MS - 1)) begin
                bcnt <= '0;
                blink <= ~blink;
            end else begin
                bcnt <= bcnt + 1'b1;
            end
        end
    end
endmodule

// [design/trsc_press.sv]
// trsc_press: classifies each press of N buttons as short or long.
// assumes one-cycle millisecond tick and synchronised held levels.
`timescale 1ns/10ps
module trsc_press import trsc_pkg::*; #(
    parameter int N = 1,
    parameter int HOLD_MS = TRSC_ENC_HOLD_MS
) (
    input wire logic sys_clk,
    input wire logic rst,
    trsc_press_if.cls pif
);
    localparam int CW = $clog2(HOLD_MS + 1);
    localparam logic [CW-1:0] HOLD = CW'(HOLD_MS);

    logic [CW-1:0] cnt [N];
    logic [N-1:0] prev;

    // counter saturates at the threshold so a long hold fires exactly once
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prev <= '0;
            pif.short_p <= '0;
            pif.long_p <= '0;
            for (int i = 0; i < N; i++) begin
                cnt[i] <= '0;
            end
        end else begin
            prev <= pif.held;
            for (int i = 0; i < N; i++) begin
                pif.short_p[i] <= prev[i] & ~pif.held[i] & (cnt[i] < HOLD);
                pif.long_p[i] <= pif.held[i] & pif.tick & (cnt[i] == HOLD - 1'b1);
                if (!pif.held[i]) begin
                    cnt[i] <= '0;
                end else if (pif.tick && cnt[i] != HOLD) begin
                    cnt[i] <= cnt[i] + 1'b1;
                end
            end
        end
    end
endmodule

// [tb/trsc_op_model.sv]
// trsc_op_model: operator who taps shift, then holds the slate switch right.
// assumes go is a sys_clk level from the bench; the switch drops as soon as go falls.
`timescale 1ns/10ps
module trsc_op_model (
    input wire logic sys_clk,
    input wire logic go,
    output logic shift_btn,
    output logic slate_sw
);
    int n = 0;
    // shift fully released well before the switch moves, as a hand would do
    always @(posedge sys_clk) begin
        n <= go ? n + 1 : 0;
        shift_btn <= go && n < 8;
        slate_sw <= go && n > 16;
    end
endmodule

// [tb/tb.sv]
// tb: self-checking bench driving operator pins and the register port.
// assumes the millisecond tick is shortened to four clocks.
`timescale 1ns/10ps
module tb import trsc_pkg::*;;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] track_btn = '0, track_media = 12'hfff, led_b, led_g;
    logic [7:0] enc_btn = '0, input_on = 8'hff, reg_addr = '0, ring_g, ring_r;
    logic shift_btn, slate_sw, go = 1'b0, tb1 = 1'b0, hp_step = 1'b0, hp_up = 1'b0;
    logic setup_toggle = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, route_on, solo, slate_on;
    logic gshow, tb1_on, in8_send, in8_blk, b0, tb2 = 1'b0, tb2_on, ftrim, sled, ind2;
    logic [4:0] setup_index = '0;
    logic [3:0] sel;
    logic [6:0] gain;
    logic [19:0] dest;
    logic [31:0] reg_wdata = '0, reg_rdata;
    int mismatches = 0, num_checks = 0, cyc = 0, trims = 0, lit = 0;

    trsc_top #(.MS_CYCLES(4)) u_trsc_top (.sys_clk(sys_clk), .rst(rst),
        .track_btn(track_btn), .enc_btn(enc_btn), .shift_btn(shift_btn), .slate_sw(slate_sw),
        .input_on(input_on), .track_media(track_media), .talkback_circuit_one_req(tb1),
        .talkback_circuit_two_req(tb2), .hp_step(hp_step), .hp_up(hp_up),
        .setup_toggle(setup_toggle), .setup_index(setup_index), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .track_led_blue(led_b), .track_led_green(led_g), .ring_green(ring_g),
        .ring_red(ring_r), .route_mode_on(route_on), .sel_track(sel), .hp_solo_en(solo),
        .force_trim(ftrim), .shift_led_blue(sled), .talkback_two_return_two_indicator(ind2),
        .slate_on(slate_on), .talkback_circuit_one_on(tb1_on), .talkback_circuit_two_on(tb2_on),
        .in8_send(in8_send), .in8_route_block(in8_blk), .slate_dest(dest),
        .gain_show(gshow), .slate_gain(gain));
    trsc_op_model u_trsc_op_model (.sys_clk(sys_clk), .go(go), .shift_btn(shift_btn),
        .slate_sw(slate_sw));

    initial forever #10 sys_clk = ~sys_clk;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // a hang must still reach the verdict
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        trims <= trims + int'(ftrim);
        lit <= lit + int'(ind2 && sled);
        if (cyc == 20000) begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a, logic [31:0] exp, string what);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(what, reg_rdata, exp);
    endtask

    // hold one track or encoder button for n clocks, then let synchronisers settle
    task automatic push(bit enc, int idx, int n);
        @(posedge sys_clk);
        enc_btn[idx] <= enc;
        track_btn[idx] <= !enc;
        repeat (n) @(posedge sys_clk);
        enc_btn <= '0;
        track_btn <= '0;
        repeat (30) @(posedge sys_clk);
        #1;
    endtask

    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        rd(TRSC_REG_SRC, 0, "src");
        rd(TRSC_REG_MASK, 32'h000f_ffff, "mask");
        rd(8'h40, 0, "unmapped");
        chk("leds", {led_b, led_g, sled, ind2}, 0);
        $display("test reset done");
        push(0, 0, 40);
        rd(TRSC_REG_TRK_EN, 1, "trk_en");
        rd(TRSC_REG_ARMED, 0, "armed");
        b0 = led_b[0];
        repeat (1000) @(posedge sys_clk);
        #1 chk("blink", led_b[0] ^ b0, 1);
        chk("dark", led_b[11:1], 0);
        $display("test enable done");
        push(0, 0, 4100);
        chk("route", {route_on, solo, sel}, 6'h30);
        push(1, 0, 40);
        chk("ring", {ring_g, ring_r}, 16'h0100);
        rd(TRSC_REG_ARMED, 1, "armed");
        push(1, 0, 2100);
        chk("ring", {ring_g, ring_r}, 16'h0001);
        push(0, 0, 40);
        chk("exit", {route_on, ring_g}, 0);
        chk("trim", trims, 1);
        rd(TRSC_REG_TRK_EN, 1, "trk_en");
        chk("armed led", led_b[0], 1);
        $display("test routing done");
        @(posedge sys_clk);
        tb1 <= 1'b1;
        tb2 <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 chk("tb off", {tb1_on, tb2_on, in8_send}, 0);
        wr(TRSC_REG_SRC, 2);
        wr(TRSC_REG_SRC, 3);
        rd(TRSC_REG_SRC, 2, "src");
        chk("in8", {tb1_on, tb2_on, in8_send, in8_blk}, 4'hf);
        @(posedge sys_clk);
        tb1 <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 chk("tb two", {tb1_on, tb2_on, in8_send}, 3'h3);
        @(posedge sys_clk);
        tb2 <= 1'b0;
        $display("test source done");
        @(posedge sys_clk);
        go <= 1'b1;
        repeat (40) @(posedge sys_clk);
        #1 chk("slate", {slate_on, dest}, 21'h1f_ffff);
        for (int d = 0; d < 2; d++) begin
            repeat (50) begin
                @(posedge sys_clk);
                hp_step <= 1'b1;
                hp_up <= (d == 1);
                @(posedge sys_clk);
                hp_step <= 1'b0;
            end
            repeat (4) @(posedge sys_clk);
            #1 chk("gain", gain, (d == 1) ? 7'h06 : 7'h58);
        end
        repeat (1010) @(posedge sys_clk);
        #1 chk("show", gshow, 1);
        chk("slate led", lit != 0, 1);
        go <= 1'b0;
        repeat (6) @(posedge sys_clk);
        #1 chk("slate off", {slate_on, dest, ind2}, 0);
        rd(TRSC_REG_STATUS, 32'h4, "status");
        @(posedge sys_clk);
        setup_toggle <= 1'b1;
        setup_index <= 5'h03;
        @(posedge sys_clk);
        setup_toggle <= 1'b0;
        rd(TRSC_REG_MASK, 32'h000f_fff7, "mask");
        $display("test slate done");
        print_verdict();
    end
endmodule
